// File: inc/tsc_pkg.sv
package tsc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int          TSC_ADDR_W     = 16;
    localparam logic [15:0] CTRL_OFS       = 16'h0000;
    localparam logic [15:0] MODE_OFS       = 16'h0004;
    localparam logic [15:0] STAT_OFS       = 16'h0008;
    localparam logic [3:0]  REG_PAGE       = 4'h0;
    localparam logic [3:0]  CM_LOW_PAGE    = 4'h1;
    localparam logic [3:0]  CM_HIGH_PAGE   = 4'h2;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // ------------------------------------------------------------------
    // Control and mode-select fields
    // ------------------------------------------------------------------
    localparam int CTRL_VAR_BIT   = 4;
    localparam int CTRL_BPE_BIT   = 3;
    localparam int MODE_START_BIT = 0;
    localparam int MODE_PAT_LSB   = 1;
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_BANK_LSB  = 1;
    localparam logic       VAR_EN_RST  = 1'b0;
    localparam logic       BP_EN_RST   = 1'b0;
    localparam logic [2:0] PATTERN_RST = 3'h0;

    // ------------------------------------------------------------------
    // Connection-memory entry layout
    // ------------------------------------------------------------------
    localparam int CML_W          = 16;
    localparam int CMH_W          = 5;
    localparam int CM_MODE_BIT    = 0;
    localparam int CM_CHAN_LSB    = 1;
    localparam int CM_STREAM_LSB  = 9;
    localparam int CM_DELAY_BIT   = 14;
    localparam int CM_LAW_BIT     = 15;
    localparam int CM_MSG_LSB     = 3;
    localparam int CM_SPEC_LSB    = 1;
    localparam logic [1:0] SPEC_MESSAGE = 2'h1;
    localparam int CMH_VOICE_BIT  = 0;
    localparam int CMH_IN_LAW_BIT = 1;
    localparam int CMH_OUT_LAW_BIT = 2;
    localparam logic [7:0] LAW_FLIP_MASK = 8'h55;
    localparam logic [7:0] IDLE_BYTE     = 8'hff;

    // ------------------------------------------------------------------
    // Throughput delay and timing
    // ------------------------------------------------------------------
    localparam int FRAME_BANKS    = 3;
    localparam int VAR_MIN_GAP    = 7;
    localparam int SLOT_CYCLES_DEF = 4;
    localparam int CHANNELS_DEF   = 256;
    localparam int CLK_PERIOD_NS  = 25;
    localparam int BP_TIME_NS     = 250000;
    localparam int BP_MIN_CYCLES  = (BP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] BP_MIN_FRAMES = 2'h2;

    // ------------------------------------------------------------------
    // Bus carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                  awvalid;
        logic [TSC_ADDR_W-1:0] awaddr;
        logic                  wvalid;
        logic [31:0]           wdata;
        logic [3:0]            wstrb;
        logic                  bready;
        logic                  arvalid;
        logic [TSC_ADDR_W-1:0] araddr;
        logic                  rready;
    } tsc_axil_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } tsc_axil_rsp_t;

endpackage

// File: design/tsc_ram.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// One write port, two registered read ports
// ----------------------------------------------------------------------
module tsc_ram #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 256,
    parameter int AW    = $clog2(DEPTH)
) (
    // Clock
    input  wire logic             core_clk,
    // Write port
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    // Read ports
    input  wire logic [AW-1:0]    rd_a_addr,
    output logic      [WIDTH-1:0] rd_a_data,
    input  wire logic [AW-1:0]    rd_b_addr,
    output logic      [WIDTH-1:0] rd_b_data
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_a_data <= mem[rd_a_addr];
        rd_b_data <= mem[rd_b_addr];
    end

endmodule

// File: design/tsc_switch.sv
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps

module tsc_switch
    import tsc_pkg::*;
#(
    parameter int CHANNELS      = tsc_pkg::CHANNELS_DEF,
    parameter int SLOT_CYCLES   = tsc_pkg::SLOT_CYCLES_DEF,
    parameter int BP_MIN_CYC    = tsc_pkg::BP_MIN_CYCLES,
    parameter int OUT_STREAM_ID = 0
) (
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    // Register bus
    input  wire tsc_pkg::tsc_axil_req_t axil_req,
    output tsc_pkg::tsc_axil_rsp_t      axil_rsp,
    // Serial streams, one byte per channel slot
    input  wire logic [7:0]            serial_input_stream,
    output logic      [7:0]            serial_output_stream,
    output logic                       out_valid,
    output logic [$clog2(CHANNELS)-1:0] out_channel,
    output logic                       frame_start
);

    localparam int IW  = $clog2(CHANNELS);
    localparam int DAW = $clog2(FRAME_BANKS * CHANNELS);
    localparam int SW  = $clog2(SLOT_CYCLES);

    typedef struct packed {
        logic                  aw_full;
        logic [TSC_ADDR_W-1:0] aw_addr;
        logic                  w_full;
        logic [31:0]           w_data;
        logic [3:0]            w_strb;
        logic                  b_valid;
        logic [1:0]            b_resp;
        logic                  r_wait;
        logic                  r_high;
        logic                  r_valid;
        logic [31:0]           r_data;
        logic [1:0]            r_resp;
        logic                  var_en;
        logic                  bp_en;
        logic [2:0]            pattern;
        logic                  bp_start;
        logic [IW:0]           bp_addr;
        logic [1:0]            bp_frames;
        logic [31:0]           bp_timer;
        logic [SW-1:0]         slot_cyc;
        logic [IW-1:0]         chan;
        logic [1:0]            bank_w;
        logic [IW-1:0]         p_chan;
        logic [CML_W-1:0]      p_low;
        logic [CMH_W-1:0]      p_high;
        logic [7:0]            o_data;
        logic                  o_valid;
        logic [IW-1:0]         o_chan;
        logic [7:0]            in_s1;
        logic [7:0]            in_s2;
    } tsc_state_t;

    tsc_state_t st_reg;
    tsc_state_t st_next;

    // Memory hookup.
    logic             cml_we;
    logic             cmh_we;
    logic [IW-1:0]    cm_waddr;
    logic [CML_W-1:0] cml_wdata;
    logic [CMH_W-1:0] cmh_wdata;
    logic [IW-1:0]    cm_host_raddr;
    logic [IW-1:0]    cm_sw_raddr;
    logic [CML_W-1:0] cml_host_q;
    logic [CMH_W-1:0] cmh_host_q;
    logic [CML_W-1:0] cml_sw_q;
    logic [CMH_W-1:0] cmh_sw_q;
    logic             dm_we;
    logic [DAW-1:0]   dm_waddr;
    logic [DAW-1:0]   dm_raddr;
    logic [7:0]       dm_q;

    tsc_ram #(.WIDTH(CML_W), .DEPTH(CHANNELS)) u_cm_low (
        .core_clk  (core_clk),
        .wr_en     (cml_we),
        .wr_addr   (cm_waddr),
        .wr_data   (cml_wdata),
        .rd_a_addr (cm_host_raddr),
        .rd_a_data (cml_host_q),
        .rd_b_addr (cm_sw_raddr),
        .rd_b_data (cml_sw_q)
    );

    tsc_ram #(.WIDTH(CMH_W), .DEPTH(CHANNELS)) u_cm_high (
        .core_clk  (core_clk),
        .wr_en     (cmh_we),
        .wr_addr   (cm_waddr),
        .wr_data   (cmh_wdata),
        .rd_a_addr (cm_host_raddr),
        .rd_a_data (cmh_host_q),
        .rd_b_addr (cm_sw_raddr),
        .rd_b_data (cmh_sw_q)
    );

    // Three frame banks give the two-frame constant delay its history.
    tsc_ram #(.WIDTH(8), .DEPTH(FRAME_BANKS * CHANNELS)) u_data (
        .core_clk  (core_clk),
        .wr_en     (dm_we),
        .wr_addr   (dm_waddr),
        .wr_data   (st_reg.in_s2),
        .rd_a_addr ('0),
        .rd_a_data (),
        .rd_b_addr (dm_raddr),
        .rd_b_data (dm_q)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    logic                  wr_go;
    logic                  host_cm_wr;
    logic                  bp_run;
    logic                  bp_fill;
    logic                  last_slot;
    logic                  frame_end;
    logic [3:0]            aw_page;
    logic [9:0]            aw_idx;
    logic [3:0]            ar_page;
    logic [9:0]            ar_idx;
    logic [IW-1:0]         src_chan;
    logic [4:0]            src_stream;
    logic signed [IW+1:0]  gap;
    logic [1:0]            rd_bank;
    logic [7:0]            out_byte;

    always_comb begin
        st_next     = st_reg;
        cml_we      = 1'b0;
        cmh_we      = 1'b0;
        cm_waddr    = '0;
        cml_wdata   = '0;
        cmh_wdata   = '0;
        host_cm_wr  = 1'b0;
        gap         = '0;
        rd_bank     = st_reg.bank_w;
        out_byte    = IDLE_BYTE;
        src_chan    = st_reg.p_low[CM_CHAN_LSB +: IW];
        src_stream  = st_reg.p_low[CM_STREAM_LSB +: 5];
        aw_page     = st_reg.aw_addr[15:12];
        aw_idx      = st_reg.aw_addr[11:2];
        ar_page     = axil_req.araddr[15:12];
        ar_idx      = axil_req.araddr[11:2];
        cm_host_raddr = ar_idx[IW-1:0];
        last_slot   = (st_reg.slot_cyc == SW'(SLOT_CYCLES - 1));
        frame_end   = last_slot && (st_reg.chan == IW'(CHANNELS - 1));
        bp_run      = st_reg.bp_start && st_reg.bp_en;
        bp_fill     = bp_run && (st_reg.bp_addr < (IW + 1)'(CHANNELS));

        st_next.in_s1 = serial_input_stream;
        st_next.in_s2 = st_reg.in_s1;

        // Write address and data are taken independently.
        if (axil_req.awvalid && !st_reg.aw_full) begin
            st_next.aw_full = 1'b1;
            st_next.aw_addr = axil_req.awaddr;
        end
        if (axil_req.wvalid && !st_reg.w_full) begin
            st_next.w_full = 1'b1;
            st_next.w_data = axil_req.wdata;
            st_next.w_strb = axil_req.wstrb;
        end
        if (st_reg.b_valid && axil_req.bready) begin
            st_next.b_valid = 1'b0;
        end

        // Block programming sequencer; dropping start or enable stops it
        // and discards progress, so a later start begins from entry zero.
        if (bp_run) begin
            if (bp_fill) begin
                cml_we    = 1'b1;
                cmh_we    = 1'b1;
                cm_waddr  = st_reg.bp_addr[IW-1:0];
                cml_wdata = {13'h0000, st_reg.pattern};
                cmh_wdata = '0;
                st_next.bp_addr = st_reg.bp_addr + 1'b1;
            end
            // A partial first frame needs one extra frame end.
            if (frame_end && st_reg.bp_frames != BP_MIN_FRAMES + 2'h1) begin
                st_next.bp_frames = st_reg.bp_frames + 1'b1;
            end
            if (st_reg.bp_timer != 32'(BP_MIN_CYC)) begin
                st_next.bp_timer = st_reg.bp_timer + 32'h1;
            end
            if (!bp_fill && st_reg.bp_frames == BP_MIN_FRAMES + 2'h1 &&
                st_reg.bp_timer == 32'(BP_MIN_CYC)) begin
                st_next.bp_start = 1'b0;
            end
        end else begin
            st_next.bp_addr   = '0;
            st_next.bp_frames = '0;
            st_next.bp_timer  = '0;
        end

        // Register writes come after the sequencer so a host write in the
        // same cycle as completion is the one that sticks.
        wr_go = st_reg.aw_full && st_reg.w_full && !st_reg.b_valid;
        if (wr_go) begin
            st_next.aw_full = 1'b0;
            st_next.w_full  = 1'b0;
            st_next.b_valid = 1'b1;
            st_next.b_resp  = RESP_OKAY;
            if (aw_page == REG_PAGE && st_reg.aw_addr == CTRL_OFS) begin
                if (st_reg.w_strb[0]) begin
                    st_next.var_en = st_reg.w_data[CTRL_VAR_BIT];
                    st_next.bp_en  = st_reg.w_data[CTRL_BPE_BIT];
                end
            end else if (aw_page == REG_PAGE && st_reg.aw_addr == MODE_OFS) begin
                if (st_reg.w_strb[0]) begin
                    st_next.pattern  = st_reg.w_data[MODE_PAT_LSB +: 3];
                    st_next.bp_start = st_reg.w_data[MODE_START_BIT];
                end
            end else if (aw_page == REG_PAGE && st_reg.aw_addr == STAT_OFS) begin
                st_next.b_resp = RESP_OKAY;
            end else if (aw_page == CM_LOW_PAGE && aw_idx < 10'(CHANNELS) &&
                         st_reg.w_strb[1:0] == 2'h3) begin
                host_cm_wr = 1'b1;
                cml_we     = 1'b1;
                cmh_we     = 1'b0;
                cm_waddr   = aw_idx[IW-1:0];
                cml_wdata  = st_reg.w_data[CML_W-1:0];
            end else if (aw_page == CM_HIGH_PAGE && aw_idx < 10'(CHANNELS) &&
                         st_reg.w_strb[0]) begin
                host_cm_wr = 1'b1;
                cml_we     = 1'b0;
                cmh_we     = 1'b1;
                cm_waddr   = aw_idx[IW-1:0];
                cmh_wdata  = st_reg.w_data[CMH_W-1:0];
            end else begin
                st_next.b_resp = RESP_SLVERR;
            end
        end
        // A host entry write pre-empts the fill for one cycle.
        if (host_cm_wr && bp_fill) begin
            st_next.bp_addr = st_reg.bp_addr;
        end

        // Reads of the connection memory take one extra cycle for the RAM.
        if (st_reg.r_valid && axil_req.rready) begin
            st_next.r_valid = 1'b0;
        end
        if (st_reg.r_wait) begin
            st_next.r_wait  = 1'b0;
            st_next.r_valid = 1'b1;
            st_next.r_data  = st_reg.r_high ? {27'h0, cmh_host_q} : {16'h0, cml_host_q};
        end else if (axil_req.arvalid && !st_reg.r_valid) begin
            st_next.r_resp = RESP_OKAY;
            st_next.r_data = '0;
            if (ar_page == REG_PAGE && axil_req.araddr == CTRL_OFS) begin
                st_next.r_valid = 1'b1;
                st_next.r_data[CTRL_VAR_BIT] = st_reg.var_en;
                st_next.r_data[CTRL_BPE_BIT] = st_reg.bp_en;
            end else if (ar_page == REG_PAGE && axil_req.araddr == MODE_OFS) begin
                st_next.r_valid = 1'b1;
                st_next.r_data[MODE_PAT_LSB +: 3]  = st_reg.pattern;
                st_next.r_data[MODE_START_BIT]     = st_reg.bp_start;
            end else if (ar_page == REG_PAGE && axil_req.araddr == STAT_OFS) begin
                st_next.r_valid = 1'b1;
                st_next.r_data[STAT_BUSY_BIT]      = bp_run;
                st_next.r_data[STAT_BANK_LSB +: 2] = st_reg.bank_w;
            end else if ((ar_page == CM_LOW_PAGE || ar_page == CM_HIGH_PAGE) &&
                         ar_idx < 10'(CHANNELS)) begin
                st_next.r_wait = 1'b1;
                st_next.r_high = (ar_page == CM_HIGH_PAGE);
            end else begin
                st_next.r_valid = 1'b1;
                st_next.r_resp  = RESP_SLVERR;
            end
        end

        // Channel slot timing.
        st_next.slot_cyc = last_slot ? '0 : st_reg.slot_cyc + 1'b1;
        if (last_slot) begin
            st_next.chan = (st_reg.chan == IW'(CHANNELS - 1)) ? '0 : st_reg.chan + 1'b1;
        end
        if (frame_end) begin
            st_next.bank_w = (st_reg.bank_w == 2'h2) ? 2'h0 : st_reg.bank_w + 2'h1;
        end

        // Slot cycle 1: connection entry for output channel n is out.
        if (st_reg.slot_cyc == SW'(0)) begin
            st_next.p_chan = st_reg.chan;
        end
        if (st_reg.slot_cyc == SW'(1)) begin
            st_next.p_low  = cml_sw_q;
            st_next.p_high = cmh_sw_q;
        end

        // Source frame bank: two frames back for constant delay, or the
        // newest bank that already holds channel m for variable delay.
        gap = $signed({2'b00, st_reg.p_chan}) - $signed({2'b00, src_chan});
        if (st_reg.p_low[CM_DELAY_BIT] && st_reg.var_en) begin
            if (gap >= $signed((IW + 2)'(VAR_MIN_GAP)) &&
                OUT_STREAM_ID >= int'(src_stream)) begin
                rd_bank = st_reg.bank_w;
            end else begin
                rd_bank = (st_reg.bank_w == 2'h0) ? 2'h2 : st_reg.bank_w - 2'h1;
            end
        end else begin
            rd_bank = (st_reg.bank_w == 2'h2) ? 2'h0 : st_reg.bank_w + 2'h1;
        end

        // Slot cycle 3: data byte is out, build the output channel.
        if (st_reg.p_low[CM_MODE_BIT]) begin
            if (st_reg.p_low[CM_SPEC_LSB +: 2] == SPEC_MESSAGE) begin
                out_byte = st_reg.p_low[CM_MSG_LSB +: 8];
            end
        end else begin
            out_byte = dm_q;
        end
        if (st_reg.p_low[CM_LAW_BIT] && st_reg.p_high[CMH_VOICE_BIT] &&
            st_reg.p_high[CMH_IN_LAW_BIT] != st_reg.p_high[CMH_OUT_LAW_BIT]) begin
            out_byte = out_byte ^ LAW_FLIP_MASK;
        end
        st_next.o_valid = (st_reg.slot_cyc == SW'(3));
        if (st_reg.slot_cyc == SW'(3)) begin
            st_next.o_data = out_byte;
            st_next.o_chan = st_reg.p_chan;
        end
    end

    assign cm_sw_raddr = st_reg.chan;
    assign dm_we       = (st_reg.slot_cyc == SW'(0));
    assign dm_waddr    = DAW'(st_reg.bank_w) * DAW'(CHANNELS) + DAW'(st_reg.chan);
    assign dm_raddr    = DAW'(rd_bank) * DAW'(CHANNELS) + DAW'(src_chan);

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_reg          <= '0;
            st_reg.var_en   <= VAR_EN_RST;
            st_reg.bp_en    <= BP_EN_RST;
            st_reg.pattern  <= PATTERN_RST;
            st_reg.o_data   <= IDLE_BYTE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign axil_rsp.awready = !st_reg.aw_full;
    assign axil_rsp.wready  = !st_reg.w_full;
    assign axil_rsp.bvalid  = st_reg.b_valid;
    assign axil_rsp.bresp   = st_reg.b_resp;
    assign axil_rsp.arready = !st_reg.r_wait && !st_reg.r_valid;
    assign axil_rsp.rvalid  = st_reg.r_valid;
    assign axil_rsp.rdata   = st_reg.r_data;
    assign axil_rsp.rresp   = st_reg.r_resp;

    assign serial_output_stream = st_reg.o_data;
    assign out_valid            = st_reg.o_valid;
    assign out_channel          = st_reg.o_chan;
    assign frame_start          = (st_reg.slot_cyc == '0) && (st_reg.chan == '0);

endmodule

// File: testbench/tsc_switch_monitor.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Bus and stream checks
// ---------------------------------------------------------------
module tsc_switch_monitor
    import tsc_pkg::*;
#(
    parameter int CHANNELS = 256
) (
    // Clock and reset
    input wire logic                          core_clk,
    input wire logic                          sys_rst,
    // Register bus
    input wire tsc_pkg::tsc_axil_req_t        axil_req,
    input wire tsc_pkg::tsc_axil_rsp_t        axil_rsp,
    // Streams
    input wire logic [7:0]                    serial_input_stream,
    input wire logic [7:0]                    serial_output_stream,
    input wire logic                          out_valid,
    input wire logic [$clog2(CHANNELS)-1:0]   out_channel,
    input wire logic                          frame_start
);
    import tsc_pkg::*;
    logic [3:0]                  pg_reg;
    logic [$clog2(CHANNELS)-1:0] ch_plus;
    assign ch_plus = out_channel + 1'b1;
    // The page of the read in flight decides which bits must read zero.
    always_ff @(posedge core_clk) begin
        if (sys_rst)
            pg_reg <= 4'h0;
        else if (axil_req.arvalid && axil_rsp.arready)
            pg_reg <= axil_req.araddr[15:12];
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wr_resp_a: assert property (
        axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready
        |=> ##1 axil_rsp.bvalid) else $error("write answer late");
    b_hold_a: assert property (
        axil_rsp.bvalid && !axil_req.bready |=> axil_rsp.bvalid && $stable(axil_rsp.bresp))
        else $error("write answer dropped");
    r_hold_a: assert property (
        axil_rsp.rvalid && !axil_req.rready |=> axil_rsp.rvalid && $stable(axil_rsp.rdata))
        else $error("read answer dropped");
    rd_lat_a: assert property (
        axil_req.arvalid && axil_rsp.arready |-> ##[1:2] axil_rsp.rvalid)
        else $error("read answer late");
    low_zero_a: assert property (
        axil_rsp.rvalid && pg_reg == CM_LOW_PAGE |-> axil_rsp.rdata[31:16] == 16'h0)
        else $error("low entry upper bits set");
    high_zero_a: assert property (
        axil_rsp.rvalid && pg_reg == CM_HIGH_PAGE |-> axil_rsp.rdata[31:5] == 27'h0)
        else $error("high entry upper bits set");
    unmapped_read_a: assert property (
        axil_rsp.rvalid && pg_reg > 4'h2 |-> axil_rsp.rresp == RESP_SLVERR
        && axil_rsp.rdata == 32'h0) else $error("unmapped read answered");
    slot_pace_a: assert property (
        out_valid |-> ##4 (out_valid && out_channel == $past(ch_plus, 4)))
        else $error("channel sequence broken");
    out_hold_a: assert property (
        out_valid |=> $stable(serial_output_stream) [*3]) else $error("output byte moved");
    cover property (axil_rsp.bvalid && axil_req.bready);
    cover property (axil_rsp.rvalid && pg_reg == CM_LOW_PAGE);
    cover property (frame_start ##[1:80] frame_start);
endmodule

bind tsc_switch tsc_switch_monitor #(.CHANNELS(CHANNELS)) i_mon (
    .core_clk(core_clk), .sys_rst(sys_rst), .axil_req(axil_req), .axil_rsp(axil_rsp),
    .serial_input_stream(serial_input_stream), .serial_output_stream(serial_output_stream),
    .out_valid(out_valid), .out_channel(out_channel), .frame_start(frame_start));

// File: testbench/tsc_stream_src.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Serial source: each byte carries its frame and channel number
// ---------------------------------------------------------------
module tsc_stream_src #(
    parameter int CHANNELS = 16
) (
    // Clock and reset
    input wire logic  core_clk,
    input wire logic  sys_rst,
    // Frame timing
    input wire logic  frame_start,
    // Stream
    output logic [7:0] serial_input_stream,
    output logic [3:0] frame_no
);
    int         pos;
    logic [3:0] ch;
    assign ch = 4'(pos / 4 + 1);
    initial serial_input_stream = 8'h00;
    // Bytes change early in a slot so the sampling point sees a stable value.
    always @(posedge core_clk) begin
        if (sys_rst) begin
            pos <= 0;
            frame_no <= 4'h0;
        end else begin
            pos <= frame_start ? 1 : pos + 1;
            if (frame_start)
                frame_no <= frame_no + 4'h1;
            if (pos % 4 == 0)
                serial_input_stream <= {frame_no + 4'(ch == 4'h0 || frame_start), ch};
        end
    end
endmodule

// File: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import tsc_pkg::*;
    localparam int CH = 16;
    localparam int FR = CH * 4;
    logic          core_clk = 1'b0;
    logic          sys_rst = 1'b1;
    tsc_axil_req_t req = '0;
    tsc_axil_rsp_t rsp;
    logic [7:0]    sin, sout;
    logic [3:0]    och, fno;
    logic          ov, fs, chk = 1'b0, var_on = 1'b0;
    logic [15:0]   lo [CH];
    logic [4:0]    hi [CH];
    logic [31:0]   rd, r;
    logic [1:0]    rr;
    int            failures = 0, n_compared = 0, seed = 32'h7318, t, i, p, cyc = 0, c0;
    initial forever #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;
    tsc_switch #(.CHANNELS(CH), .SLOT_CYCLES(4), .BP_MIN_CYC(20)) i_dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .axil_req(req), .axil_rsp(rsp),
        .serial_input_stream(sin), .serial_output_stream(sout), .out_valid(ov),
        .out_channel(och), .frame_start(fs));
    tsc_stream_src #(.CHANNELS(CH)) i_src (.core_clk(core_clk), .sys_rst(sys_rst),
        .frame_start(fs), .serial_input_stream(sin), .frame_no(fno));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // One transfer; payloads stay put until each channel's ready is sampled.
    task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
        logic aw, w, ar, done;
        @(posedge core_clk);
        {req.awvalid, req.wvalid, req.bready} <= {3{wr}};
        {req.arvalid, req.rready} <= {2{!wr}};
        {req.awaddr, req.araddr, req.wdata, req.wstrb} <= {a, a, d, 4'hf};
        for (t = 0; t < 50; t++) begin
            @(negedge core_clk);
            aw = req.awvalid && rsp.awready;
            w = req.wvalid && rsp.wready;
            ar = req.arvalid && rsp.arready;
            done = wr ? rsp.bvalid : rsp.rvalid;
            {rd, rr} = {rsp.rdata, wr ? rsp.bresp : rsp.rresp};
            @(posedge core_clk);
            if (aw) req.awvalid <= 1'b0;
            if (w) req.wvalid <= 1'b0;
            if (ar) req.arvalid <= 1'b0;
            if (done) begin
                {req.bready, req.rready} <= 2'b00;
                break;
            end
        end
        if (t == 50) begin
            failures++;
            wrap_up();
        end
    endtask
    function automatic logic [7:0] expb(int n, int f);
        logic [15:0] l;
        logic [7:0]  b;
        int          x;
        l = lo[n];
        x = f - ((l[14] && var_on) ? ((n - int'(l[4:1]) >= 7 && l[13:9] == 5'h0) ? 0 : 1) : 2);
        b = l[0] ? l[10:3] : {x[3:0], l[4:1]};
        if (l[15] && hi[n][0] && hi[n][1] != hi[n][2]) b = b ^ LAW_FLIP_MASK;
        return b;
    endfunction
    always @(negedge core_clk) if (chk && ov === 1'b1)
        check("out byte", {24'h0, sout}, {24'h0, expb(och, fno)});
    initial begin
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        bus(0, 16'h3000, 32'h0);
        check("unmapped data", rd, 32'h0);
        check("unmapped resp", {30'h0, rr}, {30'h0, RESP_SLVERR});
        bus(1, CTRL_OFS, 32'h8);
        bus(1, MODE_OFS, 32'ha);
        bus(1, MODE_OFS, 32'hb);
        c0 = cyc;
        rd = 32'h1;
        for (i = 0; i < 2000 && rd[0] !== 1'b0; i++) bus(0, MODE_OFS, 32'h0);
        check("start cleared", {31'h0, rd[0]}, 32'h0);
        check("fill length", 32'(cyc - c0 >= 2 * FR), 32'h1);
        for (i = 0; i < CH; i++) begin
            bus(0, 16'(16'h1000 + 4 * i), 32'h0);
            check("low fill", rd, 32'h5);
            bus(0, 16'(16'h2000 + 4 * i), 32'h0);
            check("high fill", rd, 32'h0);
        end
        bus(0, CTRL_OFS, 32'h0);
        check("enable kept", rd, 32'h8);
        bus(1, MODE_OFS, 32'h5);
        bus(1, CTRL_OFS, 32'h0);
        bus(0, STAT_OFS, 32'h0);
        check("abort busy", {31'h0, rd[0]}, 32'h0);
        bus(1, MODE_OFS, 32'h0);
        for (p = 0; p < 2; p++) begin
            var_on = p[0];
            bus(1, CTRL_OFS, 32'(p << 4));
            for (i = 0; i < CH; i++) begin
                r = $random(seed);
                hi[i] = {2'h0, r[2:0]};
                lo[i] = r[3] ? {r[4], 4'h0, r[15:8], 3'b011}
                             : {r[4], r[5], 4'h0, r[6], 4'h0, r[19:16], 1'b0};
                bus(1, 16'(16'h2000 + 4 * i), {27'h0, hi[i]});
                bus(1, 16'(16'h1000 + 4 * i), {16'h0, lo[i]});
            end
            bus(0, 16'h100c, 32'h0);
            check("low readback", rd, {16'h0, lo[3]});
            repeat (4 * FR) @(posedge core_clk);
            chk = 1'b1;
            repeat (2 * FR) @(posedge core_clk);
            chk = 1'b0;
        end
        wrap_up();
    end
endmodule
